// ===== mmc_params.svh
// Purpose: Named constants for measurement mode control
// Assumes: 250 MHz core clock
// Notes: Included by the package and both ends
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH

// ----------------------------------------
// Device register map
// ----------------------------------------
`define MMC_MC_ADDR 8'h26
`define MMC_AC_ADDR 8'h27
`define MMC_MC_RST 2
`define MMC_MC_OST 1
`define MMC_MC_RUN 0
`define MMC_AC_LOAD 5
`define MMC_MC_RUNMASK 8'h07
`define MMC_AC_RSVD 8'hc0

// ----------------------------------------
// Timing
// ----------------------------------------
`define MMC_CLK_PERIOD_NS 4
`define MMC_STEP_UNIT_S 1
`define MMC_SEC_CYCLES (`MMC_STEP_UNIT_S * 1000000000 / `MMC_CLK_PERIOD_NS)
`define MMC_MS_CYCLES (1000000 / `MMC_CLK_PERIOD_NS)
`define MMC_BOOT_CYCLES 16
`define MMC_SP0_MS 6
`define MMC_SP1_MS 10
`define MMC_SP2_MS 18
`define MMC_SP3_MS 34
`define MMC_SP4_MS 66
`define MMC_SP5_MS 130
`define MMC_SP6_MS 258
`define MMC_SP7_MS 512

// ----------------------------------------
// Host controller register map
// ----------------------------------------
`define MMC_HC_ADDR 3'h0
`define MMC_HC_WDATA 3'h1
`define MMC_HC_READ 3'h2
`define MMC_HC_STAT 3'h3
`define MMC_HC_RDATA 3'h4

`endif

// ===== mmc_pkg.sv
// Purpose: Types shared by both ends
// Assumes: mmc_params.svh constants
// Notes: All-zero struct value is the reset state
`include "mmc_params.svh"
package mmc_pkg;
	typedef enum logic [2:0] {MMC_STBY, MMC_ACTIVE, MMC_CONV, MMC_STOP, MMC_BOOT} mmc_dev_st_t;
	typedef enum logic [2:0] {MMC_IDLE, MMC_WAIT, MMC_RD, MMC_CAP, MMC_PRE, MMC_FIN} mmc_host_st_t;

	typedef struct packed {
		mmc_dev_st_t st;
		logic altitude_select;
		logic raw;
		logic [2:0] os;
		logic one_shot_trigger;
		logic run;
		logic load;
		logic asel;
		logic [3:0] step;
		logic arm;
		logic solo;
		logic got;
		logic conv_req;
		logic busy;
		logic active;
		logic pend;
		logic alt_out;
		logic [31:0] pre;
		logic [15:0] secs;
		logic [31:0] spc;
		logic [7:0] boot;
		logic [7:0] rdata;
		logic [19:0] out_p;
		logic [11:0] out_t;
		logic [15:0] lat_p;
		logic [7:0] lat_t;
		logic [15:0] sel_p;
		logic [7:0] sel_t;
	} mmc_dev_t;

	typedef struct packed {
		mmc_host_st_t st;
		logic rd_op;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] cur;
		logic [7:0] l_addr;
		logic [7:0] l_wdata;
		logic l_wr;
		logic l_rd;
		logic busy;
		logic refused;
		logic loaded;
		logic [7:0] sw_rdata;
	} mmc_host_t;
endpackage

// ===== mmc_link_if.sv
// Purpose: Register link between host end and device end
// Assumes: Both ends on core_clk
// Notes: rdata valid the cycle after rd
`timescale 1ns/10ps
`default_nettype none
interface mmc_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic busy;
	modport dev (input addr, input wdata, input wr, input rd, output rdata, output busy);
	modport host (output addr, output wdata, output wr, output rd, input rdata, input busy);
endinterface
`default_nettype wire

// ===== mmc_device.sv
// Purpose: Device end, measurement sequencing and alarm target control
// Assumes: Conversion engine outside answers conv_req with conv_done
// Notes: Control state is one struct, registered once
//
// Function
// - Reset bit starts reboot in any mode
// - Reboot restores all registers to defaults
// - Standby reboots at once, active stops first
// - Link accesses ignored during reboot
// - Reset bit clears, always reads zero
// - Active one-shot measures now, bit stays set
// - Host clears then sets one-shot for more
// - Standby one-shot measures once, self-clears
// - Host reads one-shot before writing again
// - Run select zero standby, one periodic
// - Oversample code sets minimum sample spacing
// - Raw output overrides altitude select
// - Load bit latches next outputs as targets
// - Only a fresh load rise latches again
// - Host loads targets before selecting them
// - Source select picks programmed or latched targets
// - Time step is two to the exponent seconds
// - Upper acquisition bits reserved, read zero
// - Host changes fields only in standby; host enforces it for mode bits 7:3 only, not acquisition fields
// - Altitude select one altitude, zero pressure
`timescale 1ns/10ps
`default_nettype none
`include "mmc_params.svh"
module mmc_device
	import mmc_pkg::*;
#(
	parameter int SEC_CYCLES = `MMC_SEC_CYCLES,
	parameter int MS_CYCLES = `MMC_MS_CYCLES,
	parameter int BOOT_CYCLES = `MMC_BOOT_CYCLES
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	mmc_link_if.dev link,
	output logic conv_req,
	output logic conv_raw,
	output logic conv_alt,
	output logic [2:0] conv_os,
	input wire logic conv_done,
	input wire logic [19:0] conv_pres,
	input wire logic [11:0] conv_temp,
	input wire logic [7:0] pressure_target_high,
	input wire logic [7:0] pressure_target_low,
	input wire logic [7:0] temperature_target,
	output logic [19:0] out_pres,
	output logic [11:0] out_temp,
	output logic [15:0] tgt_pres_sel,
	output logic [7:0] tgt_temp_sel,
	output logic dev_active,
	output logic reboot_active
);
	mmc_dev_t s_q;
	mmc_dev_t s_d;
	logic [31:0] sp_limit;
	logic [9:0] sp_ms;
	logic wr_mc;
	logic wr_ac;
	logic rst_req;
	logic ost_rise;
	logic sec_wrap;
	logic period_hit;
	logic start;

	// ----------------------------------------
	// Minimum sample spacing
	// ----------------------------------------
	// Spacing in ms per oversample code
	always_comb
	begin
		unique case (s_q.os)
			3'h0: sp_ms = 10'(`MMC_SP0_MS);
			3'h1: sp_ms = 10'(`MMC_SP1_MS);
			3'h2: sp_ms = 10'(`MMC_SP2_MS);
			3'h3: sp_ms = 10'(`MMC_SP3_MS);
			3'h4: sp_ms = 10'(`MMC_SP4_MS);
			3'h5: sp_ms = 10'(`MMC_SP5_MS);
			3'h6: sp_ms = 10'(`MMC_SP6_MS);
			3'h7: sp_ms = 10'(`MMC_SP7_MS);
		endcase
	end
	assign sp_limit = 32'(sp_ms) * 32'(MS_CYCLES);

	// ----------------------------------------
	// Decode and timers
	// ----------------------------------------
	// Accesses count only outside reboot
	assign wr_mc = link.wr && !s_q.busy && link.addr == `MMC_MC_ADDR;
	assign wr_ac = link.wr && !s_q.busy && link.addr == `MMC_AC_ADDR;
	assign rst_req = wr_mc && link.wdata[`MMC_MC_RST];
	assign ost_rise = wr_mc && link.wdata[`MMC_MC_OST] && !s_q.one_shot_trigger;
	assign sec_wrap = s_q.pre == 32'(SEC_CYCLES - 1);
	assign period_hit = sec_wrap && s_q.secs == ((16'h1 << s_q.step) - 16'h1);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.conv_req = 1'b0;
		s_d.rdata = 8'h00;
		start = 1'b0;
		// Register reads, reset bit and reserved bits read zero
		if (link.rd && !s_q.busy)
		begin
			if (link.addr == `MMC_MC_ADDR)
				s_d.rdata = {s_q.altitude_select, s_q.raw, s_q.os, 1'b0, s_q.one_shot_trigger, s_q.run};
			else if (link.addr == `MMC_AC_ADDR)
				s_d.rdata = {2'b00, s_q.load, s_q.asel, s_q.step};
		end
		// Register writes; reset bit is never stored
		if (wr_mc && !rst_req)
		begin
			s_d.altitude_select = link.wdata[7];
			s_d.raw = link.wdata[6];
			s_d.os = link.wdata[5:3];
			s_d.one_shot_trigger = link.wdata[`MMC_MC_OST];
			s_d.run = link.wdata[`MMC_MC_RUN];
		end
		if (rst_req)
			s_d.busy = 1'b1;
		if (wr_ac)
		begin
			s_d.load = link.wdata[`MMC_AC_LOAD];
			s_d.asel = link.wdata[4];
			s_d.step = link.wdata[3:0];
			// Arm only on a fresh rise, disarm on clear
			if (!link.wdata[`MMC_AC_LOAD])
				s_d.arm = 1'b0;
			else if (!s_q.load)
				s_d.arm = 1'b1;
		end
		// Period timer runs only while active
		if (s_q.run && (s_q.st == MMC_ACTIVE || s_q.st == MMC_CONV))
		begin
			s_d.pre = sec_wrap ? 32'h0 : s_q.pre + 32'h1;
			if (sec_wrap)
				s_d.secs = period_hit ? 16'h0 : s_q.secs + 16'h1;
		end
		else
		begin
			s_d.pre = 32'h0;
			s_d.secs = 16'h0;
			s_d.pend = 1'b0;
		end
		// Mode sequencing
		unique case (s_q.st)
			MMC_STBY:
			begin
				if (rst_req)
					s_d.st = MMC_BOOT;
				else if (s_d.run)
				begin
					s_d.st = MMC_ACTIVE;
					start = ost_rise;
				end
				else if (ost_rise)
				begin
					start = 1'b1;
					s_d.solo = 1'b1;
				end
			end
			MMC_ACTIVE:
			begin
				if (rst_req)
					s_d.st = MMC_STOP;
				else if (!s_d.run)
					s_d.st = MMC_STBY;
				else if (ost_rise || period_hit || s_q.pend)
				begin
					start = 1'b1;
					s_d.pre = 32'h0;
					s_d.secs = 16'h0;
				end
			end
			MMC_CONV:
			begin
				if (conv_done && !s_q.got)
				begin
					s_d.got = 1'b1;
					s_d.out_p = conv_pres;
					s_d.out_t = conv_temp;
					if (s_q.arm)
					begin
						s_d.lat_p = conv_pres[19:4];
						s_d.lat_t = conv_temp[11:4];
						s_d.arm = 1'b0;
					end
				end
				if (ost_rise && !s_q.solo)
					s_d.pend = 1'b1;
				if (s_q.spc < sp_limit)
					s_d.spc = s_q.spc + 32'h1;
				if (rst_req)
					s_d.st = MMC_STOP;
				else if ((s_q.got || conv_done) && s_q.spc >= sp_limit)
				begin
					if (s_q.solo)
					begin
						s_d.one_shot_trigger = 1'b0;
						s_d.solo = 1'b0;
						s_d.st = MMC_STBY;
					end
					else
						s_d.st = s_d.run ? MMC_ACTIVE : MMC_STBY;
				end
			end
			MMC_STOP:
			begin
				// Forced to standby before the reboot starts
				s_d.run = 1'b0;
				s_d.solo = 1'b0;
				s_d.st = MMC_BOOT;
			end
			MMC_BOOT:
			begin
				s_d = '0;
				if (s_q.boot != 8'(BOOT_CYCLES - 1))
				begin
					s_d.st = MMC_BOOT;
					s_d.busy = 1'b1;
					s_d.boot = s_q.boot + 8'h1;
				end
			end
			default:
				s_d.st = MMC_STBY;
		endcase
		// Launch a conversion with current mode bits
		if (start)
		begin
			s_d.st = MMC_CONV;
			s_d.conv_req = 1'b1;
			s_d.spc = 32'h0;
			s_d.got = 1'b0;
			s_d.pend = 1'b0;
		end
		s_d.active = s_d.st == MMC_ACTIVE || s_d.st == MMC_CONV;
		s_d.alt_out = s_d.altitude_select && !s_d.raw;
		// Alarm target source
		s_d.sel_p = s_d.asel ? s_d.lat_p : {pressure_target_high, pressure_target_low};
		s_d.sel_t = s_d.asel ? s_d.lat_t : temperature_target;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Outputs straight from the state register
	assign link.rdata = s_q.rdata;
	assign link.busy = s_q.busy;
	assign conv_req = s_q.conv_req;
	assign conv_raw = s_q.raw;
	assign conv_alt = s_q.alt_out;
	assign conv_os = s_q.os;
	assign out_pres = s_q.out_p;
	assign out_temp = s_q.out_t;
	assign tgt_pres_sel = s_q.sel_p;
	assign tgt_temp_sel = s_q.sel_t;
	assign dev_active = s_q.active;
	assign reboot_active = s_q.busy;
endmodule
`default_nettype wire

// ===== mmc_host.sv
// Purpose: Host end, checked register access to the device
// Assumes: Software port with read data one cycle after the strobe
// Notes: Every write is preceded by a read-back of the target
`timescale 1ns/10ps
`default_nettype none
`include "mmc_params.svh"
module mmc_host
	import mmc_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	mmc_link_if.host link,
	input wire logic [2:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata
);
	mmc_host_t s_q;
	mmc_host_t s_d;
	logic [7:0] cur;
	logic is_mc;
	logic is_ac;
	logic refuse;
	logic pre;

	// ----------------------------------------
	// Checks on the read-back value
	// ----------------------------------------
	assign cur = link.rdata;
	assign is_mc = s_q.addr == `MMC_MC_ADDR;
	assign is_ac = s_q.addr == `MMC_AC_ADDR;
	// Refuse unsafe writes
	assign refuse = (is_mc && !cur[`MMC_MC_RUN] && cur[`MMC_MC_OST])
		|| (is_mc && cur[`MMC_MC_RUN]
		&& ((s_q.data & ~`MMC_MC_RUNMASK) != (cur & ~`MMC_MC_RUNMASK)))
		|| (is_ac && s_q.data[4] && !s_q.loaded && !s_q.data[`MMC_AC_LOAD]);
	// Clear-then-set for re-triggers
	assign pre = (is_mc && cur[`MMC_MC_RUN] && cur[`MMC_MC_OST] && s_q.data[`MMC_MC_OST])
		|| (is_ac && cur[`MMC_AC_LOAD] && s_q.data[`MMC_AC_LOAD]);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.l_wr = 1'b0;
		s_d.l_rd = 1'b0;
		s_d.sw_rdata = 8'h00;
		// Software register reads
		if (sw_rd)
		begin
			if (sw_addr == `MMC_HC_ADDR)
				s_d.sw_rdata = s_q.addr;
			else if (sw_addr == `MMC_HC_WDATA)
				s_d.sw_rdata = s_q.data;
			else if (sw_addr == `MMC_HC_STAT)
				s_d.sw_rdata = {5'h0, s_q.loaded, s_q.refused, s_q.busy};
			else if (sw_addr == `MMC_HC_RDATA)
				s_d.sw_rdata = s_q.cur;
		end
		// Software writes to the data or read register start an operation when idle
		if (sw_wr && !s_q.busy)
		begin
			if (sw_addr == `MMC_HC_ADDR)
				s_d.addr = sw_wdata;
			else if (sw_addr == `MMC_HC_WDATA || sw_addr == `MMC_HC_READ)
			begin
				s_d.rd_op = sw_addr == `MMC_HC_READ;
				if (sw_addr == `MMC_HC_WDATA)
					s_d.data = sw_wdata;
				s_d.busy = 1'b1;
				s_d.refused = 1'b0;
				s_d.st = MMC_WAIT;
			end
		end
		// Link sequencing
		unique case (s_q.st)
			MMC_IDLE:
				s_d.busy = s_d.busy;
			MMC_WAIT:
			begin
				if (!link.busy)
				begin
					s_d.l_rd = 1'b1;
					s_d.l_addr = s_q.addr;
					s_d.st = MMC_RD;
				end
			end
			MMC_RD:
				s_d.st = MMC_CAP;
			MMC_CAP:
			begin
				s_d.cur = cur;
				if (s_q.rd_op || refuse)
				begin
					s_d.refused = !s_q.rd_op;
					s_d.busy = 1'b0;
					s_d.st = MMC_IDLE;
				end
				else
				begin
					s_d.l_wr = 1'b1;
					s_d.st = pre ? MMC_PRE : MMC_FIN;
					if (!pre)
						s_d.l_wdata = s_q.data;
					else if (is_mc)
						s_d.l_wdata = cur & ~(8'h1 << `MMC_MC_OST);
					else
						s_d.l_wdata = s_q.data & ~(8'h1 << `MMC_AC_LOAD);
				end
			end
			MMC_PRE:
			begin
				s_d.l_wr = 1'b1;
				s_d.l_wdata = s_q.data;
				s_d.st = MMC_FIN;
			end
			MMC_FIN:
			begin
				// Track whether targets were loaded since the last reset write
				if (is_ac && s_q.data[`MMC_AC_LOAD])
					s_d.loaded = 1'b1;
				if (is_mc && s_q.data[`MMC_MC_RST])
					s_d.loaded = 1'b0;
				s_d.busy = 1'b0;
				s_d.st = MMC_IDLE;
			end
			default:
				s_d.st = MMC_IDLE;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign link.addr = s_q.l_addr;
	assign link.wdata = s_q.l_wdata;
	assign link.wr = s_q.l_wr;
	assign link.rd = s_q.l_rd;
	assign sw_rdata = s_q.sw_rdata;
endmodule
`default_nettype wire

// ===== mmc_monitor.sv
// Purpose: Link assertions between host end and device end
// Assumes: One clock, asynchronous active-high reset
// Notes: Sees only the link signals
`timescale 1ns/10ps
`default_nettype none
module mmc_monitor
#(
	parameter int BOOT_CYCLES = 16
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic busy
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [7:0] busy_cnt_q;
	logic [7:0] busy_cnt_d;
	logic loaded_q;
	logic loaded_d;

	// Reboot length and whether a target load was written since the last reboot
	always_comb
	begin
		busy_cnt_d = busy ? busy_cnt_q + 8'h01 : 8'h00;
		loaded_d = busy ? 1'b0 : (loaded_q | (wr && addr == 8'h27 && wdata[5]));
	end

	// Register helper state
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busy_cnt_q <= 8'h00;
			loaded_q <= 1'b0;
		end
		else
		begin
			busy_cnt_q <= busy_cnt_d;
			loaded_q <= loaded_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	chk_reset_starts_boot: assert property (wr && !busy && addr == 8'h26 && wdata[2] |=> busy)
		else $error("reset write did not start reboot");
	chk_boot_length: assert property (!busy && busy_cnt_q != 8'h00 |->
		busy_cnt_q == BOOT_CYCLES || busy_cnt_q == BOOT_CYCLES + 1)
		else $error("reboot length wrong");
	chk_read_timing: assert property (rdata != 8'h00 |-> $past(rd) && !$past(busy))
		else $error("read data outside its slot");
	chk_reset_bit_zero: assert property ($past(rd) && $past(addr) == 8'h26 |-> !rdata[2])
		else $error("reset bit read as one");
	chk_reserved_zero: assert property ($past(rd) && $past(addr) == 8'h27 |-> rdata[7:6] == 2'b00)
		else $error("reserved bits read nonzero");
	chk_readback_first: assert property (wr && addr == 8'h26 |-> $past(rd, 2) || $past(rd, 3))
		else $error("one-shot register written without read-back");
	chk_oneshot_preclear: assert property (wr && $past(wr) && addr == 8'h26 && $past(addr) == 8'h26
		|-> !$past(wdata[1]))
		else $error("one-shot not cleared before set");
	chk_load_preclear: assert property (wr && $past(wr) && addr == 8'h27 && $past(addr) == 8'h27
		|-> !$past(wdata[5]))
		else $error("load not cleared before set");
	chk_source_loaded: assert property (wr && !busy && addr == 8'h27 && wdata[4] && !wdata[5]
		|-> loaded_q)
		else $error("latched targets selected before a load");
endmodule
`default_nettype wire

// ===== measurement_mode_control_tb.sv
// Purpose: Self-checking bench, host end driving device end
// Assumes: Second and millisecond counts shortened
// Notes: Bench stands in for the conversion engine
`timescale 1ns/10ps
`default_nettype none
module measurement_mode_control_tb;
	import mmc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int SEC = 20;
	localparam int MS = 2;
	logic core_clk, sys_rst, sw_wr, sw_rd, conv_done, conv_req, conv_raw, conv_alt;
	logic dev_active, reboot_active;
	logic [2:0] sw_addr, conv_os;
	logic [7:0] sw_wdata, sw_rdata, pressure_target_high, pressure_target_low, temperature_target;
	logic [7:0] d, s, v, elt;
	logic [15:0] tgt_pres_sel, elp;
	logic [7:0] tgt_temp_sel;
	logic [19:0] conv_pres, out_pres;
	logic [11:0] conv_temp, out_temp;
	logic [31:0] r, r2;
	logic act_q;
	int seed, n_mismatch, total_checks, cyc, n_req, t_req, t_prev, t_idle, dly, bcnt, b0, n0, i;

	mmc_link_if link();
	mmc_device #(.SEC_CYCLES(SEC), .MS_CYCLES(MS), .BOOT_CYCLES(16)) i_mmc_device (.core_clk,
		.sys_rst, .link(link.dev), .conv_req, .conv_raw, .conv_alt, .conv_os, .conv_done,
		.conv_pres, .conv_temp, .pressure_target_high, .pressure_target_low,
		.temperature_target, .out_pres, .out_temp, .tgt_pres_sel, .tgt_temp_sel, .dev_active,
		.reboot_active);
	mmc_host i_mmc_host (.core_clk, .sys_rst, .link(link.host), .sw_addr, .sw_wdata, .sw_wr,
		.sw_rd, .sw_rdata);
	mmc_monitor #(.BOOT_CYCLES(16)) i_mmc_monitor (.core_clk, .sys_rst, .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .busy(link.busy));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic int sp(input logic [2:0] c);
		return MS * ((c == 3'h7) ? 512 : (4 << c) + 2);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic swr(input logic [2:0] a, input logic [7:0] x);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= x;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask

	task automatic swrd(input logic [2:0] a, output logic [7:0] x);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		@(negedge core_clk);
		x = sw_rdata;
	endtask

	// Poll host status until its operation ends
	task automatic opw();
		int n;
		n = 0;
		do
		begin
			swrd(3'h3, s);
			n++;
		end
		while (s[0] !== 1'b0 && n < 300);
		if (n >= 300)
			n_mismatch++;
	endtask

	task automatic wdev(input logic [7:0] a, input logic [7:0] x);
		swr(3'h0, a);
		swr(3'h1, x);
		opw();
	endtask

	task automatic rdev(input logic [7:0] a, output logic [7:0] x);
		swr(3'h0, a);
		swr(3'h2, 8'h00);
		opw();
		swrd(3'h4, x);
	endtask

	task automatic idle(input bit conv);
		int n;
		n = 0;
		while ((conv ? dev_active : reboot_active) !== 1'b0 && n < 1500)
		begin
			@(posedge core_clk);
			n++;
		end
		repeat (2) @(posedge core_clk);
	endtask

	// ----------------------------------------
	// Clock, conversion engine, counters
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		r = $random(seed);
		cyc <= cyc + 1;
		act_q <= dev_active;
		conv_done <= 1'b0;
		if (act_q && !dev_active)
			t_idle <= cyc;
		if (reboot_active)
			bcnt <= bcnt + 1;
		if (conv_req)
		begin
			n_req <= n_req + 1;
			t_prev <= t_req;
			t_req <= cyc;
			dly <= 2 + r[1:0];
		end
		else if (dly == 1)
		begin
			conv_done <= 1'b1;
			conv_pres <= r[19:0];
			conv_temp <= r[31:20];
			dly <= 0;
		end
		else if (dly > 1)
			dly <= dly - 1;
		if (cyc == 30000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		seed = 32'h58f0;
		{sys_rst, sw_wr, sw_rd, conv_done, sw_addr, sw_wdata, act_q} = {1'b1, 15'h0};
		{conv_pres, conv_temp, cyc, n_req, t_req, t_prev, t_idle, dly, bcnt} = '0;
		{pressure_target_high, pressure_target_low, temperature_target} = 24'($random(seed));
		{n_mismatch, total_checks, elp, elt} = '0;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdev(8'h26, d); chk(d, 8'h00);
		rdev(8'h27, d); chk(d, 8'h00);
		rdev(8'h31, d); chk(d, 8'h00);
		wdev(8'h27, 8'h10); chk(s[1], 1'b1);
		// Load and source set twice, reserved bits dropped
		for (i = 0; i < 2; i++)
		begin
			wdev(8'h27, 8'hf0);
			rdev(8'h27, d); chk(d, 8'h30);
		end
		// Standby one-shots across oversample codes
		for (i = 0; i < 4; i++)
		begin
			r2 = $random(seed);
			v = (i == 0) ? 8'h3a : (i == 1) ? 8'hc2 : (i == 2) ? 8'h82 : {r2[7:3], 3'b010};
			wdev(8'h26, v);
			// A second write while the one-shot still runs is refused
			if (i == 0)
			begin
				wdev(8'h26, v);
				chk(s[1], 1'b1);
			end
			idle(1'b1);
			chk(t_idle - t_req >= sp(v[5:3]) && t_idle - t_req <= sp(v[5:3]) + 3, 1);
			rdev(8'h26, d); chk(d, v & 8'hfd);
			chk({conv_os, conv_raw, conv_alt}, {v[5:3], v[6], v[7] & ~v[6]});
			chk({out_pres, out_temp}, {conv_pres, conv_temp});
			if (i == 0)
			begin
				{elp, elt} = {conv_pres[19:4], conv_temp[11:4]};
				wdev(8'h27, 8'h10);
			end
			chk({tgt_pres_sel, tgt_temp_sel}, {elp, elt});
		end
		wdev(8'h27, 8'h01);
		chk({tgt_pres_sel, tgt_temp_sel}, {pressure_target_high, pressure_target_low,
			temperature_target});
		// Periodic acquisition at two seconds, then one-shots while active
		wdev(8'h26, 8'h01);
		n0 = n_req;
		while (n_req < n0 + 3 && cyc < 29000) @(posedge core_clk);
		chk(t_req - t_prev, 2 * SEC);
		// Changing oversample while active is refused
		wdev(8'h26, 8'h39);
		chk(s[1], 1'b1);
		for (i = 0; i < 2; i++)
		begin
			n0 = n_req;
			wdev(8'h26, 8'h03);
			repeat (sp(3'h0) + 8) @(posedge core_clk);
			chk(n_req > n0, 1);
			rdev(8'h26, d); chk(d, 8'h03);
		end
		// Software reset from active, then from standby
		b0 = bcnt;
		wdev(8'h26, 8'h05);
		idle(1'b0);
		chk(bcnt - b0, 17);
		rdev(8'h26, d); chk(d, 8'h00);
		rdev(8'h27, d); chk(d, 8'h00);
		chk({out_pres, dev_active}, 0);
		b0 = bcnt;
		wdev(8'h26, 8'h04);
		idle(1'b0);
		chk(bcnt - b0, 16);
		stop_test();
	end
endmodule
`default_nettype wire
